// file: logic/bcc_regs.vh
// Register map, field positions and reset values of the bridge command block
`ifndef BCC_REGS_VH
`define BCC_REGS_VH
`define BCC_ADDR_W 4
`define BCC_OFF_CMD 4'h0
`define BCC_OFF_STAT 4'h1
`define BCC_OFF_IRQ_STAT 4'h2
`define BCC_OFF_IRQ_MASK 4'h3
`define BCC_OFF_DEVCTL 4'h4
`define BCC_BIT_IO 0
`define BCC_BIT_MEM 1
`define BCC_BIT_MASTER 2
`define BCC_BIT_WINV 4
`define BCC_BIT_PARITY 6
`define BCC_BIT_SYSERR 8
`define BCC_CMD_RW_MASK 32'h0000_0157
`define BCC_CMD_RESET 32'h0000_0000
`define BCC_STAT_SSE 30
`define BCC_STAT_MDP 24
`define BCC_DEVCTL_NONFATAL 1
`define BCC_DEVCTL_FATAL 2
`define BCC_EV_W 4
`define BCC_EV_MDP 0
`define BCC_EV_SSE 1
`define BCC_EV_UR 2
`define BCC_EV_BLOCKED 3
`define BCC_UNMAPPED_DATA 32'h0000_0000
`endif

// file: logic/bcc_w1c_flags.v
// Sticky flag bank: hardware set wins over write-one-to-clear
`timescale 1ns/1ps
module bcc_w1c_flags #(
    parameter W = 4
) (
    input wire clk_i,
    input wire nrst_i,
    input wire [W-1:0] set_i,
    input wire [W-1:0] clr_i,
    output reg [W-1:0] flag_o
);
    // -------------------------------------------------------------
    // Flag bits
    // -------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < W; gi = gi + 1) begin : g_flag
            // Set takes precedence so an event in the clearing cycle survives
            always @(posedge clk_i) begin
                if (!nrst_i) begin
                    flag_o[gi] <= 1'b0;
                end else if (set_i[gi]) begin
                    flag_o[gi] <= 1'b1;
                end else if (clr_i[gi]) begin
                    flag_o[gi] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule // bcc_w1c_flags

// file: logic/bcc_bridge_command.v
// Bridge command bits, error reporting gates and request routing decisions
//
// What this block does
// - Interrupt-disable bit reads zero, read-only
// - Legacy bits 9,7,5,3 read-only zero
// - System-error enable gates own error reporting
// - Forward PCI-side system errors when enabled
// - Report if command or device-control enable
// - Parity response permits master parity flag
// - Write-invalidate enable promotes memory writes
// - Master enable gates PCIe bus mastering
// - Memory disabled: PCIe memory gets UR
// - PCI-side memory always forwarded upstream
// - Memory enabled: forward window hits, accept internal
// - IO disabled: PCIe IO gets UR
// - IO enabled: forward secondary-range IO
// - Parity flag never sets when response off
// - Signaled error flag set when message sent under system-error enable
`timescale 1ns/1ps
`include "bcc_regs.vh"
module bcc_bridge_command (
    input wire clk_i,
    input wire nrst_i,
    // Avalon-MM slave
    input wire [`BCC_ADDR_W-1:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    output wire irq_o,
    // Incoming PCIe request to be routed
    input wire pcie_req_valid_i,
    input wire pcie_req_is_mem_i,
    input wire pcie_req_is_io_i,
    input wire pcie_req_is_wr_i,
    input wire pcie_req_win_hit_i,
    input wire pcie_req_own_hit_i,
    input wire pcie_req_io_hit_i,
    output reg route_fwd_o,
    output reg route_accept_o,
    output reg route_ur_o,
    output reg route_winv_o,
    // PCI-side originated memory request
    input wire pci_mem_req_i,
    output reg pci_mem_fwd_o,
    // Bus mastering on PCIe
    input wire master_req_i,
    output reg master_grant_o,
    // Error sources
    input wire own_err_nonfatal_i,
    input wire own_err_fatal_i,
    input wire pci_serr_i,
    input wire poison_rx_i,
    output reg err_msg_nonfatal_o,
    output reg err_msg_fatal_o,
    // Live enables for the rest of the bridge
    output wire master_enable_o,
    output wire memory_space_enable_o,
    output wire io_space_enable_o
);
    // -------------------------------------------------------------
    // Decoding helpers
    // -------------------------------------------------------------
    // Byte-lane merge used by the command register
    // Lanes left disabled keep their old contents
    function [31:0] merge_be;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] be;
        integer k;
        begin
            merge_be = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    merge_be[k*8 +: 8] = new_v[k*8 +: 8];
                end
            end
        end
    endfunction

    // Word-index match for the write strobes
    function hit;
        input [`BCC_ADDR_W-1:0] a;
        input [`BCC_ADDR_W-1:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // -------------------------------------------------------------
    // Register map (word index on the slave port)
    // -------------------------------------------------------------
    // 0 command: bit8 system error report, bit6 parity response,
    //   bit4 write-invalidate, bit2 master, bit1 memory, bit0 I/O
    // 1 status, write one to clear: bit30 signaled system error,
    //   bit24 master data parity
    // 2 interrupt status, write one to clear: bit0 parity flag,
    //   bit1 signaled error, bit2 Unsupported Request, bit3 blocked master
    // 3 interrupt mask, same layout as word 2
    // 4 device control: bit1 non-fatal enable, bit2 fatal enable
    // Unmapped words read zero and ignore writes
    // Timing: decisions, messages and flags follow their cause by one
    //   clock; reads take one wait state, writes none

    // -------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------
    reg [31:0] bridge_command_bits;
    reg [2:0] devctl;
    reg [`BCC_EV_W-1:0] irq_mask;
    reg rd_done;
    reg [31:0] next_readdata;
    wire [1:0] stat_flags;
    wire [`BCC_EV_W-1:0] irq_flags;
    wire wr_cmd;
    wire wr_stat;
    wire wr_irq_stat;
    wire wr_devctl;
    wire wr_irq_mask;
    wire [31:0] be_bits;

    // Reads wait one cycle so that the registered word stands when
    // waitrequest drops; writes are taken at once
    assign avs_waitrequest_o = avs_read_i && !rd_done;
    assign wr_cmd = avs_write_i && hit(avs_address_i, `BCC_OFF_CMD);
    assign wr_stat = avs_write_i && hit(avs_address_i, `BCC_OFF_STAT);
    assign wr_irq_stat = avs_write_i && hit(avs_address_i, `BCC_OFF_IRQ_STAT);
    assign wr_devctl = avs_write_i && hit(avs_address_i, `BCC_OFF_DEVCTL);
    assign wr_irq_mask = avs_write_i && hit(avs_address_i, `BCC_OFF_IRQ_MASK);
    assign be_bits = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    // -------------------------------------------------------------
    // Command fields
    // -------------------------------------------------------------
    // Decoded command bits; master, memory and I/O enables also exported live to the rest of the bridge
    wire system_error_report_enable = bridge_command_bits[`BCC_BIT_SYSERR];
    wire parity_response_enable = bridge_command_bits[`BCC_BIT_PARITY];
    wire write_invalidate_enable = bridge_command_bits[`BCC_BIT_WINV];
    wire master_enable = bridge_command_bits[`BCC_BIT_MASTER];
    wire memory_space_enable = bridge_command_bits[`BCC_BIT_MEM];
    wire io_space_enable = bridge_command_bits[`BCC_BIT_IO];

    assign master_enable_o = master_enable;
    assign memory_space_enable_o = memory_space_enable;
    assign io_space_enable_o = io_space_enable;

    // Command bits; read-only positions are masked to zero on every write
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            bridge_command_bits <= `BCC_CMD_RESET;
        end else if (wr_cmd) begin
            bridge_command_bits <= merge_be(bridge_command_bits, avs_writedata_i,
                avs_byteenable_i) & `BCC_CMD_RW_MASK;
        end
    end

    // Device-control enables live in lane 0; other lanes are ignored
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            devctl <= 3'h0;
        end else if (wr_devctl && avs_byteenable_i[0]) begin
            devctl <= avs_writedata_i[2:0];
        end
    end

    // Interrupt mask, same layout as the interrupt status word
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            irq_mask <= {`BCC_EV_W{1'b0}};
        end else if (wr_irq_mask && avs_byteenable_i[0]) begin
            irq_mask <= avs_writedata_i[`BCC_EV_W-1:0];
        end
    end

    // -------------------------------------------------------------
    // Error reporting
    // -------------------------------------------------------------
    // Either enable path allows a message; the two are OR'ed
    wire nf_allowed = system_error_report_enable | devctl[`BCC_DEVCTL_NONFATAL];
    wire f_allowed = system_error_report_enable | devctl[`BCC_DEVCTL_FATAL];
    // PCI-side system errors go out only under the command enable, since
    // the device-control enables cover the bridge's own errors alone
    wire next_nf = (own_err_nonfatal_i && nf_allowed) ||
                   (pci_serr_i && system_error_report_enable);
    wire next_f = (own_err_fatal_i && f_allowed);
    wire sse_event = (next_nf || next_f) && system_error_report_enable;
    wire mdp_event = poison_rx_i && parity_response_enable;

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            err_msg_nonfatal_o <= 1'b0;
            err_msg_fatal_o <= 1'b0;
        end else begin
            err_msg_nonfatal_o <= next_nf;
            err_msg_fatal_o <= next_f;
        end
    end

    // Status flags: bit0 master data parity, bit1 signaled system error
    // A clear in the same cycle as a new event loses, so no event is missed
    bcc_w1c_flags #(
        .W(2)
    ) u_stat (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .set_i({sse_event, mdp_event}),
        .clr_i({wr_stat & avs_writedata_i[`BCC_STAT_SSE] & be_bits[`BCC_STAT_SSE],
                wr_stat & avs_writedata_i[`BCC_STAT_MDP] & be_bits[`BCC_STAT_MDP]}),
        .flag_o(stat_flags)
    );

    // -------------------------------------------------------------
    // Request routing
    // -------------------------------------------------------------
    reg next_fwd;
    reg next_accept;
    reg next_ur;
    reg next_winv;
    wire blocked_master = master_req_i && !master_enable;

    // A valid request marked neither memory nor I/O gets no decision; the
    // transaction layer never presents one. A memory request that hits no
    // window and no internal location is refused as Unsupported Request.
    // Decide forward, accept or Unsupported Request per incoming request
    always @* begin
        next_fwd = 1'b0;
        next_accept = 1'b0;
        next_ur = 1'b0;
        next_winv = 1'b0;
        if (pcie_req_valid_i && pcie_req_is_mem_i) begin
            if (!memory_space_enable) begin
                next_ur = 1'b1;
            end else if (pcie_req_own_hit_i) begin
                next_accept = 1'b1;
            end else if (pcie_req_win_hit_i) begin
                next_fwd = 1'b1;
                next_winv = pcie_req_is_wr_i && write_invalidate_enable;
            end else begin
                next_ur = 1'b1;
            end
        end else if (pcie_req_valid_i && pcie_req_is_io_i) begin
            if (io_space_enable && pcie_req_io_hit_i) begin
                next_fwd = 1'b1;
            end else begin
                next_ur = 1'b1;
            end
        end
    end

    // Grants follow the live master enable; software is expected to set it
    // before relying on forwarding toward the link
    // Registered decisions; upstream memory path ignores the space enable
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            route_fwd_o <= 1'b0;
            route_accept_o <= 1'b0;
            route_ur_o <= 1'b0;
            route_winv_o <= 1'b0;
            pci_mem_fwd_o <= 1'b0;
            master_grant_o <= 1'b0;
        end else begin
            route_fwd_o <= next_fwd;
            route_accept_o <= next_accept;
            route_ur_o <= next_ur;
            route_winv_o <= next_winv;
            pci_mem_fwd_o <= pci_mem_req_i;
            master_grant_o <= master_req_i && master_enable;
        end
    end

    // -------------------------------------------------------------
    // Interrupt flags
    // -------------------------------------------------------------
    // Causes: bit0 parity flag, bit1 signaled error, bit2 UR, bit3 blocked master
    wire [`BCC_EV_W-1:0] ev_set;
    assign ev_set = {blocked_master, next_ur, sse_event, mdp_event};

    bcc_w1c_flags #(
        .W(`BCC_EV_W)
    ) u_irq (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .set_i(ev_set),
        .clr_i({`BCC_EV_W{wr_irq_stat & avs_byteenable_i[0]}} &
               avs_writedata_i[`BCC_EV_W-1:0]),
        .flag_o(irq_flags)
    );

    // Level output stays high while any unmasked flag is set
    // Masking hides a flag from the pin but never clears it
    assign irq_o = |(irq_flags & irq_mask);

    // -------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------
    // Read multiplexer; unmapped words return zero
    always @* begin
        next_readdata = `BCC_UNMAPPED_DATA;
        case (avs_address_i)
            `BCC_OFF_CMD: begin
                next_readdata = bridge_command_bits;
            end
            `BCC_OFF_STAT: begin
                next_readdata[`BCC_STAT_SSE] = stat_flags[1];
                next_readdata[`BCC_STAT_MDP] = stat_flags[0];
            end
            `BCC_OFF_IRQ_STAT: begin
                next_readdata[`BCC_EV_W-1:0] = irq_flags;
            end
            `BCC_OFF_IRQ_MASK: begin
                next_readdata[`BCC_EV_W-1:0] = irq_mask;
            end
            `BCC_OFF_DEVCTL: begin
                next_readdata[2:0] = devctl;
            end
            default: begin
                next_readdata = `BCC_UNMAPPED_DATA;
            end
        endcase
    end

    // One wait state per read: the word is loaded in the first cycle
    // and stands while waitrequest is low in the second
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            rd_done <= 1'b0;
        end else begin
            rd_done <= avs_read_i && !rd_done;
        end
    end

    // Read data register, loaded only in the first cycle of a read
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !rd_done) begin
            avs_readdata_o <= next_readdata;
        end
    end
endmodule // bcc_bridge_command

// file: tb/bcc_bridge_command_properties.sv
// Port-level checks of the bridge command block
`timescale 1ns/1ps
module bcc_bridge_command_properties (
    input wire clk_i,
    input wire nrst_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    input wire avs_read_i,
    input wire pcie_req_valid_i,
    input wire pcie_req_is_mem_i,
    input wire pcie_req_is_io_i,
    input wire pcie_req_is_wr_i,
    input wire pcie_req_win_hit_i,
    input wire pcie_req_own_hit_i,
    input wire pcie_req_io_hit_i,
    input wire route_fwd_o,
    input wire route_ur_o,
    input wire route_winv_o,
    input wire pci_mem_req_i,
    input wire pci_mem_fwd_o,
    input wire master_req_i,
    input wire master_grant_o,
    input wire own_err_nonfatal_i,
    input wire pci_serr_i,
    input wire err_msg_nonfatal_o,
    input wire master_enable_o,
    input wire memory_space_enable_o,
    input wire io_space_enable_o
);
    // ------------------------------------------------------------
    // One clock domain, reset disables everything
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire mreq = pcie_req_valid_i && pcie_req_is_mem_i;
    wire ireq = pcie_req_valid_i && pcie_req_is_io_i;
    // Bits 10,9,7,5 exist in no register of the map
    a_fixed_zero: assert property ((avs_readdata_o & 32'h0000_06a0) == 32'h0)
        else $error("fixed bit read as one");
    a_no_stall: assert property (avs_waitrequest_o |-> avs_read_i ##1 !avs_waitrequest_o)
        else $error("waitrequest not a single read wait");
    a_mem_off_ur: assert property (mreq && !memory_space_enable_o |=> route_ur_o && !route_fwd_o)
        else $error("memory request not refused");
    a_mem_fwd: assert property (mreq && memory_space_enable_o && pcie_req_win_hit_i
        && !pcie_req_own_hit_i |=> route_fwd_o)
        else $error("window hit not forwarded");
    a_io_off_ur: assert property (ireq && !io_space_enable_o |=> route_ur_o)
        else $error("io request not refused");
    a_io_fwd: assert property (ireq && io_space_enable_o && pcie_req_io_hit_i |=> route_fwd_o)
        else $error("io request not forwarded");
    a_winv_cause: assert property (route_winv_o |-> route_fwd_o && $past(pcie_req_is_wr_i))
        else $error("promotion without forwarded write");
    a_pci_fwd: assert property (pci_mem_req_i |=> pci_mem_fwd_o)
        else $error("pci memory request dropped");
    a_grant_gate: assert property (master_req_i |=> master_grant_o == $past(master_enable_o))
        else $error("grant disagrees with master enable");
    a_msg_cause: assert property (err_msg_nonfatal_o |-> $past(own_err_nonfatal_i || pci_serr_i))
        else $error("message without error event");
endmodule // bcc_bridge_command_properties
bind bcc_bridge_command bcc_bridge_command_properties u_props (.*);

// file: tb/bcc_rc_model.sv
// Root complex side model: presents one PCIe request per strobe
`timescale 1ns/1ps
module bcc_rc_model (
    input wire rq_go_i,
    input wire [5:0] rq_k_i,
    output wire pcie_req_valid_i,
    output wire pcie_req_is_mem_i,
    output wire pcie_req_is_io_i,
    output wire pcie_req_is_wr_i,
    output wire pcie_req_win_hit_i,
    output wire pcie_req_own_hit_i,
    output wire pcie_req_io_hit_i
);
    // Idle qualifiers show the inverse so stale values are never trusted
    wire [5:0] q = rq_go_i ? rq_k_i : ~rq_k_i;
    assign pcie_req_valid_i = rq_go_i;
    assign pcie_req_is_mem_i = q[0];
    assign pcie_req_is_io_i = ~q[0];
    assign pcie_req_is_wr_i = q[1];
    assign pcie_req_win_hit_i = q[2];
    assign pcie_req_own_hit_i = q[3];
    assign pcie_req_io_hit_i = q[4];
endmodule // bcc_rc_model

// file: tb/bcc_bridge_command_tb.sv
// Self-checking bench of the bridge command block
`timescale 1ns/1ps
module bcc_bridge_command_tb;
    reg clk_i = 1'b0, nrst_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0, rq_go_i = 1'b0;
    reg [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hf;
    reg [31:0] avs_writedata_i = 32'h0, seed = 32'd55946, lf = 32'h0, cmd = 32'h0;
    reg [5:0] rq_k_i = 6'h0;
    reg pci_mem_req_i = 0, master_req_i = 0, own_err_nonfatal_i = 0, own_err_fatal_i = 0;
    reg pci_serr_i = 0, poison_rx_i = 0, sse = 0, mdp = 0;
    reg [2:0] dc = 3'h0;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, irq_o, route_fwd_o, route_accept_o, route_ur_o, route_winv_o;
    wire pci_mem_fwd_o, master_grant_o, err_msg_nonfatal_o, err_msg_fatal_o;
    wire master_enable_o, memory_space_enable_o, io_space_enable_o, pcie_req_valid_i;
    wire pcie_req_is_mem_i, pcie_req_is_io_i, pcie_req_is_wr_i, pcie_req_win_hit_i;
    wire pcie_req_own_hit_i, pcie_req_io_hit_i;
    integer n_errors = 0, checked = 0, cyc = 0, i;
    reg [31:0] eq_rd[$];
    reg [3:0] eq_rt[$];
    reg [1:0] eq_er[$];
    bcc_bridge_command dut (.*);
    bcc_rc_model rc (.*);
    always #5 clk_i = ~clk_i;
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    // ------------------------------------------------------------
    // Comparison and reporting
    // ------------------------------------------------------------
    task cmp(input [8*8-1:0] nm, input [31:0] e, input [31:0] s);
        begin
            checked = checked + 1;
            if (s !== e) begin
                n_errors = n_errors + 1;
                $display("BAD %0s exp %h saw %h", nm, e, s);
            end
        end
    endtask
    task cmp_rd(input [31:0] e); cmp("readdata", e, avs_readdata_o); endtask
    task cmp_rt(input [3:0] e); cmp("route", e, {route_fwd_o, route_accept_o, route_ur_o, route_winv_o}); endtask
    task cmp_er(input [1:0] e); cmp("errmsg", e, {err_msg_nonfatal_o, err_msg_fatal_o}); endtask
    task cmp_irq(input e); cmp("irq", e, irq_o); endtask
    task give_verdict;
        begin
            $display("checked %0d errors %0d", checked, n_errors);
            if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // ------------------------------------------------------------
    // Drivers: each notes its expectation in a queue
    // ------------------------------------------------------------
    task bus(input w, input [3:0] a, input [31:0] d, input [31:0] ex);
        begin
            @(posedge clk_i);
            avs_address_i <= a; avs_read_i <= !w; avs_write_i <= w; avs_writedata_i <= d;
            if (!w) eq_rd.push_back(ex);
            @(posedge clk_i);
            while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
            avs_read_i <= 1'b0; avs_write_i <= 1'b0;
        end
    endtask
    // k: 0 memory else io, 1 write, 2 window hit, 3 own hit, 4 io range hit
    task req(input [5:0] k);
        begin
            @(posedge clk_i);
            rq_go_i <= 1'b1; rq_k_i <= k;
            eq_rt.push_back(k[0] ? (!cmd[1] ? 4'h2 : k[3] ? 4'h4 : k[2] ? {3'h4, k[1] & cmd[4]}
                : 4'h2) : (cmd[0] && k[4] ? 4'h8 : 4'h2));
            @(posedge clk_i);
            rq_go_i <= 1'b0;
        end
    endtask
    // s: 0 own nonfatal, 1 own fatal, 2 pci system error, 3 poisoned data
    task err(input [1:0] s);
        reg [1:0] e;
        begin
            e = s == 0 ? {cmd[8] | dc[1], 1'b0} : s == 1 ? {1'b0, cmd[8] | dc[2]}
                : s == 2 ? {cmd[8], 1'b0} : 2'h0;
            sse = sse | (cmd[8] & |e);
            mdp = mdp | (cmd[6] & s == 3);
            @(posedge clk_i);
            {own_err_nonfatal_i, own_err_fatal_i, pci_serr_i, poison_rx_i} <= 4'h8 >> s;
            if (|e) eq_er.push_back(e);
            @(posedge clk_i);
            {own_err_nonfatal_i, own_err_fatal_i, pci_serr_i, poison_rx_i} <= 4'h0;
        end
    endtask
    // Watcher: pops the oldest note whenever a result shows
    always @(posedge clk_i) begin
        if (nrst_i && avs_read_i && avs_waitrequest_o === 1'b0)
            cmp_rd(eq_rd.pop_front());
        if (nrst_i && |{route_fwd_o, route_accept_o, route_ur_o, route_winv_o} !== 1'b0)
            cmp_rt(eq_rt.pop_front());
        if (nrst_i && |{err_msg_nonfatal_o, err_msg_fatal_o} !== 1'b0)
            cmp_er(eq_er.pop_front());
    end
    // Background traffic on the pci side and master requests; ceiling stops a hang
    always @(posedge clk_i) begin
        lf <= (cyc == 0) ? xs(32'd55946 ^ 32'h1) : xs(lf);
        pci_mem_req_i <= lf[3];
        master_req_i <= lf[9];
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            give_verdict;
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        bus(0, 4'h0, 0, 32'h0);
        bus(0, 4'h1, 0, 32'h0);
        bus(1, 4'h0, 32'hffff_ffff, 0);
        bus(0, 4'h0, 0, 32'h157);
        bus(0, 4'h9, 0, 32'h0);
        for (i = 0; i <= 48; i = i + 1) begin
            if (i % 8 == 0) begin
                bus(0, 4'h1, 0, {1'b0, sse, 5'h0, mdp, 24'h0});
                bus(1, 4'h1, 32'h4100_0000, 0);
                sse = 0;
                mdp = 0;
                seed = xs(seed);
                cmd = seed & `BCC_CMD_RW_MASK;
                bus(1, 4'h0, seed, 0);
                dc = seed[10:8] & 3'h6;
                bus(1, 4'h4, seed >> 8, 0);
                bus(0, 4'h0, 0, cmd);
            end
            seed = xs(seed);
            if (i < 48) req(seed[5:0]);
            if (i < 48) err(seed[7:6]);
        end
        // Interrupt: raised by a refused request while masked, then unmasked, then cleared
        bus(1, 4'h0, 0, 0);
        bus(1, 4'h2, 32'hf, 0);
        bus(1, 4'h3, 0, 0);
        req(6'h01);
        repeat (2) @(negedge clk_i);
        cmp_irq(0);
        bus(1, 4'h3, 32'h4, 0);
        @(negedge clk_i);
        cmp_irq(1);
        bus(1, 4'h2, 32'h4, 0);
        @(negedge clk_i);
        cmp_irq(0);
        repeat (4) @(posedge clk_i);
        cmp("queues", 0, eq_rd.size() + eq_rt.size() + eq_er.size());
        give_verdict;
    end
endmodule // bcc_bridge_command_tb
